// [include/sita_pkg.sv]
package sita_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses on the bus)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DW1 = 8'h04;
   localparam logic [7:0] OFS_DW2 = 8'h08;
   localparam logic [7:0] OFS_DW3 = 8'h0C;
   localparam logic [7:0] OFS_DW4 = 8'h10;
   localparam logic [7:0] OFS_DW5 = 8'h14;
   localparam logic [7:0] OFS_CFG2 = 8'h18;
   localparam logic [7:0] OFS_PEN = 8'h1C;
   localparam logic [7:0] OFS_PVID = 8'h20;
   localparam logic [7:0] OFS_PVID3 = 8'h24;
   // ---------------------------------------------------------------
   // Command word and field positions
   // ---------------------------------------------------------------
   localparam int CMD_RD = 12;
   localparam int CMD_TH = 11;
   localparam int CMD_TL = 10;
   localparam int VLAN_EN_BIT = 15;
   localparam int CNT_OVF = 31;
   localparam int CNT_VLD = 30;
   localparam int DYN_NRDY = 71;
   localparam int DYN_EMPTY = 66;
   localparam int PEN_TX = 4;
   localparam int PVID2_LO = 16;
   typedef enum logic [1:0] {
      TB_STAT = 2'b00, TB_VLAN = 2'b01, TB_DYN = 2'b10, TB_CNT = 2'b11
   } sita_tbl_e;
   localparam int N_STAT = 8;
   localparam int N_VLAN = 16;
   localparam int N_DYN = 1024;
   localparam int N_CNT = 64;
   localparam int N_DROP = 4;
   localparam logic [2:0] DROP_NONE = 3'h4;
   localparam logic [9:0] DROP_BASE = 10'h100;
   localparam logic [10:0] DYN_FULL = 11'h400;
   localparam logic [11:0] VID_NULL = 12'h000;
   localparam logic [11:0] PVID_RST = 12'h001;
   localparam logic [2:0] PORTS_ALL = 3'h7;
   localparam logic [1:0] PORT_HOST = 2'h2;
   // ---------------------------------------------------------------
   // Table entry layouts
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] filter_id;
      logic use_filter_in_lookup;
      logic ovr;
      logic vld;
      logic [2:0] fwd;
      logic [47:0] mac;
   } sita_stat_s;
   typedef struct packed {
      logic vld;
      logic [2:0] mem;
      logic [3:0] filter_id;
      logic [11:0] vlan_id;
   } sita_vlan_s;
   typedef struct packed {
      logic vld;
      logic [1:0] ts;
      logic [1:0] port;
      logic [3:0] filter_id;
      logic [47:0] mac;
   } sita_dyn_s;
   localparam sita_vlan_s VLAN_RST = '{vld: 1'b1, mem: 3'h7, filter_id: 4'h0, vlan_id: 12'h001};
   // Byte enables to a bit mask
   function automatic logic [31:0] sel_mask(input logic [3:0] sel);
      sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction
   // Slot of an address pair in the dynamic table
   function automatic logic [9:0] dyn_hash(input logic [3:0] filter_id, input logic [47:0] mac);
      dyn_hash = mac[9:0] ^ mac[19:10] ^ {filter_id, 6'h00};
   endfunction
   // Dropped-packet counter slot, DROP_NONE when unmapped
   function automatic logic [2:0] drop_idx(input logic [9:0] a);
      if (a == DROP_BASE) drop_idx = 3'h0;
      else if (a == DROP_BASE + 10'h001) drop_idx = 3'h1;
      else if (a == DROP_BASE + 10'h003) drop_idx = 3'h2;
      else if (a == DROP_BASE + 10'h004) drop_idx = 3'h3;
      else drop_idx = DROP_NONE;
   endfunction
endpackage

// [include/sita_lkp_if.sv]
interface sita_lkp_if;
   import sita_pkg::*;
   logic vlan_en;
   logic [1:0] port;
   logic [11:0] vlan_id;
   logic [47:0] da;
   logic [47:0] sa;
   logic [2:0] rx_en;
   logic [2:0] tx_en;
   sita_stat_s stat [N_STAT];
   sita_vlan_s vlan [N_VLAN];
   sita_dyn_s dyn_da;
   sita_dyn_s dyn_sa;
   logic [3:0] filter_id;
   logic drop;
   logic ovr;
   logic [2:0] fwd;
   logic learn;
   modport core(output vlan_en, port, vlan_id, da, sa, rx_en, tx_en, stat, vlan, dyn_da, dyn_sa,
                input filter_id, drop, ovr, fwd, learn);
   modport calc(input vlan_en, port, vlan_id, da, sa, rx_en, tx_en, stat, vlan, dyn_da, dyn_sa,
                output filter_id, drop, ovr, fwd, learn);
endinterface

// [rtl/sita_lookup.sv]
module sita_lookup
   import sita_pkg::*;
(
   // Lookup request and tables
   sita_lkp_if.calc lk
);
   // ---------------------------------------------------------------
   // VLAN search, lowest matching index wins
   // ---------------------------------------------------------------
   logic vl_hit;
   logic [3:0] vl_fid;
   logic [2:0] vl_mem;
   always_comb begin
      vl_hit = 1'b0;
      vl_fid = 4'h0;
      vl_mem = PORTS_ALL;
      for (int i = N_VLAN - 1; i >= 0; i--) begin
         if (lk.vlan[i].vld && lk.vlan[i].vlan_id == lk.vlan_id) begin
            vl_hit = 1'b1;
            vl_fid = lk.vlan[i].filter_id;
            vl_mem = lk.vlan[i].mem;
         end
      end
   end
   // Without VLAN mode every packet sits in filter 0 and a miss floods to every port but the ingress one
   wire vdrop = lk.vlan_en & ~vl_hit;
   wire [3:0] filter_id = lk.vlan_en ? vl_fid : 4'h0;
   wire [2:0] members = lk.vlan_en ? vl_mem : PORTS_ALL;
   wire [2:0] ingress = 3'h1 << lk.port;
   assign lk.filter_id = filter_id;
   // ---------------------------------------------------------------
   // Static table: valid entries only, optional filter match
   // ---------------------------------------------------------------
   logic st_hit;
   sita_stat_s st;
   always_comb begin
      st_hit = 1'b0;
      st = '0;
      for (int i = N_STAT - 1; i >= 0; i--) begin
         if (lk.stat[i].vld && lk.stat[i].mac == lk.da &&
             (!lk.stat[i].use_filter_in_lookup || lk.stat[i].filter_id == filter_id)) begin
            st_hit = 1'b1;
            st = lk.stat[i];
         end
      end
   end
   // Dynamic hits compare the full filter plus address pair
   wire dd_hit = lk.dyn_da.vld & lk.dyn_da.mac == lk.da & lk.dyn_da.filter_id == filter_id;
   wire ds_hit = lk.dyn_sa.vld & lk.dyn_sa.mac == lk.sa & lk.dyn_sa.filter_id == filter_id;
   // ---------------------------------------------------------------
   // Forwarding decision: static over dynamic over flood
   // ---------------------------------------------------------------
   wire [2:0] st_fwd = (st.fwd == PORTS_ALL) ? (PORTS_ALL & ~ingress) : st.fwd;
   wire [2:0] dy_fwd = (3'h1 << lk.dyn_da.port) & ~ingress;
   wire [2:0] raw = st_hit ? st_fwd : dd_hit ? dy_fwd : (members & ~ingress);
   wire ovr = st_hit & st.ovr;
   wire rx_off = ~|(lk.rx_en & ingress);
   assign lk.ovr = ovr;
   assign lk.drop = vdrop | (rx_off & ~ovr);
   assign lk.fwd = lk.drop ? 3'h0 : ovr ? raw : (raw & lk.tx_en);
   // Learn on miss, and on a hit from another port (migration)
   assign lk.learn = ~vdrop & (~ds_hit | lk.dyn_sa.port != lk.port);
endmodule

// [rtl/sita_top.sv]
// Added by the designer: register access over Wishbone and the register addresses.
module sita_top
   import sita_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Counter events, one pulse per count
   input wire logic [N_CNT-1:0] MIB_INC,
   input wire logic [N_DROP-1:0] DROP_INC,
   // Packet lookup request
   input wire logic LK_REQ,
   input wire logic [1:0] LK_PORT,
   input wire logic LK_TAGGED,
   input wire logic [11:0] LK_VID,
   input wire logic [47:0] LK_DA,
   input wire logic [47:0] LK_SA,
   // Lookup answer
   output logic LK_DONE,
   output logic [2:0] LK_FWD,
   output logic LK_DROP,
   output logic LK_OVR
);
   sita_lkp_if lk();
   sita_lookup u_lookup (.lk(lk));

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   sita_stat_s stat_r [N_STAT];
   sita_vlan_s vlan_r [N_VLAN];
   sita_dyn_s dyn_mem [N_DYN];
   logic [N_DYN-1:0] dyn_vld_r;
   logic [10:0] dyn_cnt_r;
   logic [CNT_OVF:0] cnt_r [N_CNT];
   logic [15:0] drop_r [N_DROP];
   logic ack_r;
   logic [31:0] rdat_r;
   logic [15:0] cmd_r;
   logic busy_r;
   logic [71:0] dat_r;
   logic vlan_en_r;
   logic [6:0] pen_r;
   logic [11:0] pvid_r [3];
   logic [1:0] age_r;
   logic p_v_r;
   logic [1:0] p_port_r;
   logic [11:0] p_vid_r;
   logic [47:0] p_da_r;
   logic [47:0] p_sa_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Answer one cycle after the request; ack_r masks the request so ack drops next cycle
   wire acc = WB_CYC_I & WB_STB_I & ~ack_r;
   wire wr = acc & WB_WE_I;
   wire [31:0] wm = sel_mask(WB_SEL_I);
   wire [31:0] wd = WB_DAT_I & wm;
   wire w_cmd = wr & WB_ADR_I == OFS_CMD;
   wire w_cfg = wr & WB_ADR_I == OFS_CFG2;
   wire w_pen = wr & WB_ADR_I == OFS_PEN;
   wire w_pv = wr & WB_ADR_I == OFS_PVID;
   wire w_pv3 = wr & WB_ADR_I == OFS_PVID3;

   // Command fields
   wire op_rd = cmd_r[CMD_RD];
   wire [1:0] op_tb = cmd_r[CMD_TH:CMD_TL];
   wire [9:0] op_a = cmd_r[CMD_TL-1:0];
   wire cnt_pp = op_a[9:6] == 4'h0;
   wire [5:0] cnt_i = op_a[5:0];
   wire [2:0] drp_i = drop_idx(op_a);
   wire go = busy_r;
   wire go_cnt = go & op_rd & op_tb == TB_CNT;
   wire clr_cnt = go_cnt & cnt_pp;

   // Dynamic table status: count field is entries minus one
   wire dyn_empty = dyn_cnt_r == 11'h000;
   wire [9:0] dyn_num = dyn_empty ? 10'h000 : 10'(dyn_cnt_r - 11'h001);
   sita_dyn_s dy_rd;
   assign dy_rd = dyn_mem[op_a];

   // Read data of a finished command
   logic [71:0] op_dat;
   always_comb begin
      op_dat = '0;
      if (op_tb == TB_STAT) op_dat[57:0] = stat_r[op_a[2:0]];
      else if (op_tb == TB_VLAN) op_dat[19:0] = vlan_r[op_a[3:0]];
      else if (op_tb == TB_DYN) begin
         op_dat[DYN_EMPTY] = dyn_empty;
         op_dat[65:56] = dyn_num;
         op_dat[55:0] = {dy_rd.ts, dy_rd.port, dy_rd.filter_id, dy_rd.mac};
         op_dat[DYN_NRDY] = 1'b0;
      end else if (cnt_pp) begin
         op_dat[31:0] = cnt_r[cnt_i];
         op_dat[CNT_VLD] = 1'b1;
      end else if (drp_i != DROP_NONE) op_dat[15:0] = drop_r[drp_i[1:0]];
   end

   // Read mux; flags show the pending state while a command runs
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (WB_ADR_I == OFS_CMD) rmux[15:0] = cmd_r;
      else if (WB_ADR_I == OFS_DW1) begin
         rmux[7:0] = dat_r[71:64];
         if (busy_r && op_tb == TB_DYN) rmux[7] = 1'b1;
      end else if (WB_ADR_I == OFS_DW2) rmux[15:0] = dat_r[47:32];
      else if (WB_ADR_I == OFS_DW3) rmux[15:0] = dat_r[63:48];
      else if (WB_ADR_I == OFS_DW4) rmux[15:0] = dat_r[15:0];
      else if (WB_ADR_I == OFS_DW5) begin
         rmux[15:0] = dat_r[31:16];
         if (busy_r && op_tb == TB_CNT) rmux[CNT_VLD-16] = 1'b0;
      end else if (WB_ADR_I == OFS_CFG2) rmux[VLAN_EN_BIT] = vlan_en_r;
      else if (WB_ADR_I == OFS_PEN) rmux[6:0] = pen_r;
      else if (WB_ADR_I == OFS_PVID) rmux = {4'h0, pvid_r[1], 4'h0, pvid_r[0]};
      else if (WB_ADR_I == OFS_PVID3) rmux[11:0] = pvid_r[2];
   end

   // ---------------------------------------------------------------
   // Bus answer and control registers
   // ---------------------------------------------------------------
   // Unmapped addresses still ack, reading zero and ignoring writes
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc;
         rdat_r <= acc ? rmux : rdat_r;
      end
   end
   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = rdat_r;

   // Command write starts an operation that finishes on the next edge
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_r <= 16'h0000;
         busy_r <= 1'b0;
         vlan_en_r <= 1'b0;
         pen_r <= 7'h77;
         pvid_r <= '{PVID_RST, PVID_RST, PVID_RST};
      end else begin
         if (w_cmd) cmd_r <= (cmd_r & ~wm[15:0]) | wd[15:0];
         busy_r <= w_cmd;
         if (w_cfg && WB_SEL_I[1]) vlan_en_r <= WB_DAT_I[VLAN_EN_BIT];
         if (w_pen && WB_SEL_I[0]) pen_r <= WB_DAT_I[6:0];
         if (w_pv) pvid_r[0] <= (pvid_r[0] & ~wm[11:0]) | wd[11:0];
         if (w_pv) pvid_r[1] <= (pvid_r[1] & ~wm[27:16]) | wd[27:16];
         if (w_pv3) pvid_r[2] <= (pvid_r[2] & ~wm[11:0]) | wd[11:0];
      end
   end

   // Data words: host loads them, a finished read overwrites them
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dat_r <= '0;
      end else if (go && op_rd) begin
         dat_r <= op_dat;
      end else if (wr) begin
         if (WB_ADR_I == OFS_DW1) dat_r[71:64] <= (dat_r[71:64] & ~wm[7:0]) | wd[7:0];
         if (WB_ADR_I == OFS_DW3) dat_r[63:48] <= (dat_r[63:48] & ~wm[15:0]) | wd[15:0];
         if (WB_ADR_I == OFS_DW2) dat_r[47:32] <= (dat_r[47:32] & ~wm[15:0]) | wd[15:0];
         if (WB_ADR_I == OFS_DW5) dat_r[31:16] <= (dat_r[31:16] & ~wm[15:0]) | wd[15:0];
         if (WB_ADR_I == OFS_DW4) dat_r[15:0] <= (dat_r[15:0] & ~wm[15:0]) | wd[15:0];
      end
   end

   // Static and VLAN writes; dynamic and counter writes are ignored
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < N_STAT; i++) stat_r[i] <= '0;
         for (int i = 0; i < N_VLAN; i++) vlan_r[i] <= VLAN_RST;
      end else if (go && !op_rd) begin
         if (op_tb == TB_STAT) stat_r[op_a[2:0]] <= dat_r[57:0];
         if (op_tb == TB_VLAN) vlan_r[op_a[3:0]] <= dat_r[19:0];
      end
   end

   // ---------------------------------------------------------------
   // Statistics counters
   // ---------------------------------------------------------------
   // A count landing on the clearing read is kept, so no event is lost
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < N_CNT; i++) cnt_r[i] <= '0;
         for (int i = 0; i < N_DROP; i++) drop_r[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < N_CNT; i++) begin
            if (clr_cnt && cnt_i == 6'(i)) cnt_r[i] <= {2'b00, 29'h0, MIB_INC[i]};
            else if (MIB_INC[i])
               cnt_r[i] <= {cnt_r[i][CNT_OVF] | (&cnt_r[i][29:0]), 1'b0, 30'(cnt_r[i][29:0] + 30'h1)};
         end
         for (int i = 0; i < N_DROP; i++) begin
            if (DROP_INC[i]) drop_r[i] <= 16'(drop_r[i] + 16'h0001);
         end
      end
   end

   // ---------------------------------------------------------------
   // Packet lookup
   // ---------------------------------------------------------------
   // Null or missing tag takes the ingress port default
   wire [11:0] vid_in = (LK_TAGGED && LK_VID != VID_NULL) ? LK_VID : pvid_r[LK_PORT];
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         p_v_r <= 1'b0;
         p_port_r <= 2'h0;
         p_vid_r <= 12'h000;
         p_da_r <= '0;
         p_sa_r <= '0;
      end else begin
         p_v_r <= LK_REQ;
         if (LK_REQ) begin
            p_port_r <= LK_PORT;
            p_vid_r <= vid_in;
            p_da_r <= LK_DA;
            p_sa_r <= LK_SA;
         end
      end
   end

   wire [9:0] h_da = dyn_hash(lk.filter_id, p_da_r);
   wire [9:0] h_sa = dyn_hash(lk.filter_id, p_sa_r);
   always_comb begin
      lk.vlan_en = vlan_en_r;
      lk.port = p_port_r;
      lk.vlan_id = p_vid_r;
      lk.da = p_da_r;
      lk.sa = p_sa_r;
      lk.rx_en = pen_r[2:0];
      lk.tx_en = pen_r[PEN_TX+2:PEN_TX];
      lk.stat = stat_r;
      lk.vlan = vlan_r;
      lk.dyn_da = dyn_mem[h_da];
      lk.dyn_da.vld = dyn_vld_r[h_da];
      lk.dyn_sa = dyn_mem[h_sa];
      lk.dyn_sa.vld = dyn_vld_r[h_sa];
   end

   // Answer registered on the second edge after the request
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         LK_DONE <= 1'b0;
         LK_FWD <= 3'h0;
         LK_DROP <= 1'b0;
         LK_OVR <= 1'b0;
      end else begin
         LK_DONE <= p_v_r;
         if (p_v_r) begin
            LK_FWD <= lk.fwd;
            LK_DROP <= lk.drop;
            LK_OVR <= lk.ovr;
         end
      end
   end

   // Learning: slot keyed by filter and source; counts only fresh slots
   wire do_learn = p_v_r & lk.learn & p_port_r <= PORT_HOST;
   wire fresh = ~dyn_vld_r[h_sa];
   always_ff @(posedge CLK) begin
      if (do_learn) dyn_mem[h_sa] <= '{vld: 1'b1, ts: age_r, port: p_port_r, filter_id: lk.filter_id, mac: p_sa_r};
   end
   // Timestamp epoch advances on each new learn; static entries have no age
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dyn_vld_r <= '0;
         dyn_cnt_r <= 11'h000;
         age_r <= 2'h0;
      end else if (do_learn) begin
         dyn_vld_r[h_sa] <= 1'b1;
         age_r <= 2'(age_r + 2'h1);
         if (fresh && dyn_cnt_r != DYN_FULL) dyn_cnt_r <= 11'(dyn_cnt_r + 11'h001);
      end
   end
endmodule

// [tb/sita_top_assertions.sv]
module sita_top_assertions
   import sita_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // Lookup
   input wire logic LK_REQ,
   input wire logic LK_DONE,
   input wire logic [2:0] LK_FWD,
   input wire logic LK_DROP,
   input wire logic LK_OVR
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Last committed command was a per-port counter read
   wire cmd_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == OFS_CMD;
   wire cnt_nxt = WB_DAT_I[12:10] == 3'b111 && WB_DAT_I[9:0] < 10'h040;
   logic cnt_cmd_r;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) cnt_cmd_r <= 1'b0;
      else if (cmd_wr) cnt_cmd_r <= cnt_nxt;
   end
   property p_ack_next;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause;
      WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_done_lat;
      LK_REQ |-> ##2 LK_DONE;
   endproperty
   a_done_lat: assert property (p_done_lat) else $error("lookup answer missing");
   property p_done_cause;
      LK_DONE |-> $past(LK_REQ, 2);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("lookup answer unasked");
   property p_res_hold;
      !LK_DONE |-> $stable({LK_FWD, LK_DROP, LK_OVR});
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved");
   property p_drop_nofwd;
      LK_DONE && LK_DROP |-> LK_FWD == 3'h0;
   endproperty
   a_drop_nofwd: assert property (p_drop_nofwd) else $error("dropped yet forwarded");
   property p_dyn_rdy;
      WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_DW1 |-> !WB_DAT_O[7];
   endproperty
   a_dyn_rdy: assert property (p_dyn_rdy) else $error("entry not ready");
   property p_cnt_vld;
      cnt_cmd_r && WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_DW5 |-> WB_DAT_O[14];
   endproperty
   a_cnt_vld: assert property (p_cnt_vld) else $error("counter not valid");
endmodule

bind sita_top sita_top_assertions i_chk(.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .LK_REQ(LK_REQ), .LK_DONE(LK_DONE), .LK_FWD(LK_FWD), .LK_DROP(LK_DROP), .LK_OVR(LK_OVR));

// [tb/sita_host.sv]
module sita_host
   import sita_pkg::*;
(
   // Clock
   input wire logic clk,
   // Bus master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat_w,
   input wire logic [31:0] dat_r,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cyc, stb, we, adr, sel, dat_w} = '0;
   // One classic cycle; request held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_r;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask
   // Counter: upper word first, retried until it shows valid
   task automatic cnt_rd(input logic [9:0] ix, output logic [31:0] v);
      logic [31:0] hi, lo;
      wr(OFS_CMD, {19'h0, 3'b111, ix});
      do rd(OFS_DW5, hi); while (hi[14] !== 1'b1);
      rd(OFS_DW4, lo);
      v = {hi[15:0], lo[15:0]};
   endtask
   task automatic drop_rd(input logic [9:0] ix, output logic [31:0] v);
      wr(OFS_CMD, {19'h0, 3'b111, ix});
      rd(OFS_DW4, v);
   endtask
   // Table entry read; the dynamic table is polled until ready
   task automatic ent_rd(input sita_tbl_e t, input logic [9:0] ix, output logic [71:0] e);
      logic [31:0] w1, w3, w2, w5, w4;
      w1 = '0;
      wr(OFS_CMD, {19'h0, 1'b1, t, ix});
      if (t == TB_DYN) begin
         do rd(OFS_DW1, w1); while (w1[7] !== 1'b0);
      end
      rd(OFS_DW3, w3);
      rd(OFS_DW2, w2);
      rd(OFS_DW5, w5);
      rd(OFS_DW4, w4);
      e = {w1[7:0], w3[15:0], w2[15:0], w5[15:0], w4[15:0]};
   endtask
   // Data words loaded first, the command commits them
   task automatic ent_wr(input sita_tbl_e t, input logic [9:0] ix, input logic [71:0] e);
      wr(OFS_DW3, {16'h0, e[63:48]});
      wr(OFS_DW2, {16'h0, e[47:32]});
      wr(OFS_DW5, {16'h0, e[31:16]});
      wr(OFS_DW4, {16'h0, e[15:0]});
      wr(OFS_CMD, {19'h0, 1'b0, t, ix});
   endtask
endmodule

// [tb/tb_sita_top.sv]
module tb_sita_top
   import sita_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] M1 = 48'h0200_0000_0A00;
   localparam logic [47:0] M2 = 48'h0000_0000_0005;
   localparam logic [47:0] M4 = 48'h0000_0000_0077;
   localparam logic [47:0] M5 = 48'h0000_0000_0123;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, v;
   logic [63:0] mib = '0;
   logic [3:0] drp = '0;
   logic lk_req = 1'b0, lk_tag = 1'b0, lk_done, lk_drop, lk_ovr;
   logic [1:0] lk_port = '0;
   logic [11:0] lk_vid = '0;
   logic [47:0] lk_da = '0, lk_sa = '0;
   logic [2:0] lk_fwd;
   logic [71:0] e;
   int n_fail = 0;
   int checked = 0;
   always #10 CLK = ~CLK;
   sita_host i_host(.clk(CLK), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dat_w),
      .dat_r(dat_r), .ack(ack));
   sita_top i_dut(.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .MIB_INC(mib), .DROP_INC(drp),
      .LK_REQ(lk_req), .LK_PORT(lk_port), .LK_TAGGED(lk_tag), .LK_VID(lk_vid), .LK_DA(lk_da), .LK_SA(lk_sa),
      .LK_DONE(lk_done), .LK_FWD(lk_fwd), .LK_DROP(lk_drop), .LK_OVR(lk_ovr));
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Lookup: request taken at the next edge, answer stands for one cycle after the edge that follows
   task automatic lk(input logic [1:0] p, input logic t, input logic [11:0] vlan_id, input logic [47:0] da,
                     input logic [47:0] sa, input logic [2:0] xf, input logic xd);
      @(posedge CLK);
      {lk_req, lk_port, lk_tag, lk_vid, lk_da, lk_sa} <= {1'b1, p, t, vlan_id, da, sa};
      @(posedge CLK);
      lk_req <= 1'b0;
      @(posedge CLK);
      #1;
      chk(lk_done, 1'b1);
      chk(lk_fwd, xf);
      chk(lk_drop, xd);
   endtask
   // Count events as one-cycle pulses
   task automatic bump(input int i, input int n, input logic dr);
      repeat (n) begin
         @(posedge CLK);
         if (dr) drp <= 4'h1 << i;
         else mib <= 64'h1 << i;
         @(posedge CLK);
         {mib, drp} <= '0;
      end
   endtask
   initial begin
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
   end
   // Hang guard, generous against a few hundred cycles of tests
   initial begin
      #50000;
      n_fail++;
      give_verdict;
   end
   initial begin
      @(posedge RST_N);
      i_host.ent_rd(TB_VLAN, 10'h2, e);
      chk(e[19:0], 20'hF0001);
      i_host.ent_rd(TB_DYN, 10'h0, e);
      chk(e[66:56], {1'b1, 10'h0});
      bump(14, 3, 1'b0);
      bump(46, 5, 1'b0);
      bump(0, 2, 1'b1);
      i_host.cnt_rd(10'h00E, v);
      chk(v, 32'h4000_0003);
      i_host.cnt_rd(10'h00E, v);
      chk(v, 32'h4000_0000);
      i_host.cnt_rd(10'h02E, v);
      chk(v, 32'h4000_0005);
      repeat (2) begin
         i_host.drop_rd(10'h100, v);
         chk(v[15:0], 16'h0002);
      end
      // Index 1 is invalid, index 7 valid with override
      i_host.ent_wr(TB_STAT, 10'h1, {14'h0, 4'h0, 3'b000, 3'b001, M1});
      i_host.ent_wr(TB_STAT, 10'h7, {14'h0, 4'h3, 3'b011, 3'b100, M1});
      i_host.ent_rd(TB_STAT, 10'h7, e);
      chk(e[57:0], {10'h0DC, M1});
      lk(2'h1, 1'b0, 12'h0, M5, M2, 3'h5, 1'b0);
      lk(2'h1, 1'b0, 12'h0, M5, M1, 3'h5, 1'b0);
      lk(2'h0, 1'b0, 12'h0, M1, M4, 3'h4, 1'b0);
      lk(2'h0, 1'b0, 12'h0, M2, M4, 3'h2, 1'b0);
      // Slot of M2 with filter zero is 5
      i_host.ent_rd(TB_DYN, 10'h5, e);
      chk(e[66:56], 11'h002);
      chk(e[53:0], {2'b01, 4'h0, M2});
      // Receive disabled: only the override entry gets through
      i_host.wr(OFS_PEN, 32'h70);
      lk(2'h0, 1'b0, 12'h0, M1, M4, 3'h4, 1'b0);
      chk(lk_ovr, 1'b1);
      lk(2'h0, 1'b0, 12'h0, M2, M4, 3'h0, 1'b1);
      i_host.wr(OFS_PEN, 32'h77);
      i_host.ent_wr(TB_VLAN, 10'h3, 72'h5);
      i_host.wr(OFS_CFG2, 32'h8000);
      lk(2'h0, 1'b1, 12'h5, M5, M4, 3'h0, 1'b1);
      lk(2'h0, 1'b1, 12'h0, M5, M4, 3'h6, 1'b0);
      lk(2'h0, 1'b0, 12'h5, M5, M4, 3'h6, 1'b0);
      i_host.rd(8'hFC, v);
      chk(v, 32'h0);
      give_verdict;
   end
endmodule
